// ---- pkg/spa_pkg.sv ----
// Purpose: Shared constants and types for the status message assembler
// Assumes: Eight-byte outgoing message, byte 0 in the low bits
// Notes:   Bit positions are within their own byte
package spa_pkg;
  localparam int REMOTE_OUT_CNT = 6;
  localparam int CMD_W          = 14;
  localparam int DATA_W         = 32;
  localparam int PDO_W          = 64;
  localparam int END_SEL_W      = 8;
  localparam int SYNC_PINS      = 2;
  localparam int PIN_END        = 0;
  localparam int PIN_LIMIT      = 1;
  // Byte 0
  localparam int WARNING_BIT    = 6;
  localparam int ALARM_BIT      = 7;
  // Byte 1
  localparam int START_ECHO_BIT = 0;
  localparam int MOTION_END_BIT = 1;
  localparam int MOVING_BIT     = 2;
  localparam int AT_HOME_BIT    = 3;
  localparam int LIMIT_BIT      = 4;
  localparam int READY_BIT      = 5;
  localparam int FIXED_ONE_BIT  = 6;
  localparam int FIXED_ZERO_BIT = 7;
  // Byte 3
  localparam int TRIGGER_REQUEST_ECHO_BIT  = 6;
  localparam int ERROR_BIT      = 7;
  localparam logic [CMD_W-1:0]  CMD_RESET  = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [PDO_W-1:0]  PDO_RESET  = 64'h0000_0000_0000_4000;
  // Command codes that start motion or a sequence
  localparam logic [CMD_W-1:0]  CMD_RUN_SEQUENCE = 14'h1c05;
  localparam logic [CMD_W-1:0]  CMD_MOVE_FIRST   = 14'h1c10;
  localparam logic [CMD_W-1:0]  CMD_MOVE_LAST    = 14'h1c17;
  localparam logic [CMD_W-1:0]  CMD_RESUME       = 14'h1c19;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } spa_hs_state_e;

  function automatic logic spa_is_motion_start(input logic [CMD_W-1:0] code);
    return (code == CMD_RUN_SEQUENCE) || (code == CMD_RESUME) ||
           ((code >= CMD_MOVE_FIRST) && (code <= CMD_MOVE_LAST));
  endfunction
endpackage

// ---- pkg/spa_cmd_if.sv ----
// Purpose: Trigger handshake signals between assembler and handshake unit
// Assumes: All signals on core_clk
// Notes:   Top drives requests, handshake unit drives echoes
`timescale 1ns/1ns
interface spa_cmd_if;
  logic                       trigger;
  logic [spa_pkg::CMD_W-1:0]  cmdIn;
  logic [spa_pkg::DATA_W-1:0] dataIn;
  logic                       ready;
  logic                       startClr;
  logic                       startFault;
  logic                       procDone;
  logic                       procFault;
  logic [spa_pkg::DATA_W-1:0] procResult;
  logic                       issueValid;
  logic [spa_pkg::CMD_W-1:0]  issueCode;
  logic [spa_pkg::DATA_W-1:0] issueData;
  logic                       pending;
  logic                       trigEcho;
  logic [spa_pkg::CMD_W-1:0]  cmdEcho;
  logic [spa_pkg::DATA_W-1:0] resultData;
  logic                       errFlag;

  modport hs (
    input  trigger, cmdIn, dataIn, ready, startClr, startFault,
    input  procDone, procFault, procResult,
    output issueValid, issueCode, issueData, pending, trigEcho, cmdEcho,
    output resultData, errFlag
  );
  modport top (
    output trigger, cmdIn, dataIn, ready, startClr, startFault,
    output procDone, procFault, procResult,
    input  issueValid, issueCode, issueData, pending, trigEcho, cmdEcho,
    input  resultData, errFlag
  );
endinterface

// ---- rtl/spa_motion_end.sv ----
// Purpose: Selects the source of the motion end flag
// Assumes: Driver end input already synchronised
// Notes:   Purely combinational, registered by the caller
`timescale 1ns/1ns
module spa_motion_end (
  input  wire logic [spa_pkg::END_SEL_W-1:0] endAreaSelect,
  input  wire logic                          driverFinishSelect,
  input  wire logic                          pulseBusy,
  input  wire logic                          inEndArea,
  input  wire logic                          driverEnd,
  output logic                               motionEnd
);
  always_comb
  begin
    if (driverFinishSelect)
      motionEnd = driverEnd;
    else if (endAreaSelect == '0)
      motionEnd = ~pulseBusy;
    else
      motionEnd = ~pulseBusy & inEndArea;
  end
endmodule

// ---- rtl/spa_cmd_handshake.sv ----
// Purpose: Trigger edge capture, command issue and trigger echo
// Assumes: Master keeps code and data stable while trigger is high
// Notes:   Rising trigger edges are ignored while a command is pending
`timescale 1ns/1ns
module spa_cmd_handshake (
  input wire logic core_clk,
  input wire logic rst,
  spa_cmd_if.hs    bus
);
  spa_pkg::spa_hs_state_e state_reg;
  spa_pkg::spa_hs_state_e state_next;
  logic                   trigPrev_reg;
  logic                   trigRise;
  logic                   isMotion;
  logic                   accept;
  logic                   refuse;
  logic                   waitDone;
  logic                   errSet;
  logic                   errClr;

  always_comb
  begin
    trigRise = bus.trigger & ~trigPrev_reg;
    isMotion = spa_pkg::spa_is_motion_start(bus.cmdIn);
    accept   = trigRise && (state_reg == spa_pkg::HS_IDLE) && (bus.ready || !isMotion);
    refuse   = trigRise && (state_reg == spa_pkg::HS_IDLE) && !bus.ready && isMotion;
    waitDone = (state_reg == spa_pkg::HS_WAIT) && bus.procDone;
    errSet   = bus.startFault | refuse | (waitDone & bus.procFault);
    errClr   = bus.startClr | accept;
    state_next = state_reg;
    unique case (state_reg)
      spa_pkg::HS_IDLE: if (accept) state_next = spa_pkg::HS_WAIT;
      spa_pkg::HS_WAIT: if (bus.procDone) state_next = spa_pkg::HS_IDLE;
      default:          state_next = spa_pkg::HS_IDLE;
    endcase
  end

  assign bus.pending = (state_reg == spa_pkg::HS_WAIT);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg    <= spa_pkg::HS_IDLE;
      trigPrev_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      trigPrev_reg <= bus.trigger;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bus.issueValid <= 1'b0;
      bus.issueCode  <= spa_pkg::CMD_RESET;
      bus.issueData  <= spa_pkg::DATA_RESET;
    end
    else
    begin
      bus.issueValid <= accept;
      if (accept)
      begin
        bus.issueCode <= bus.cmdIn;
        bus.issueData <= bus.dataIn;
      end
    end
  end

  // Refused codes are echoed too, so the master sees what was rejected
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bus.cmdEcho <= spa_pkg::CMD_RESET;
    else if (accept | refuse)
      bus.cmdEcho <= bus.cmdIn;
  end

  // Completion wins over a dropped trigger in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bus.trigEcho <= 1'b0;
    else if (waitDone | refuse)
      bus.trigEcho <= 1'b1;
    else if (!bus.trigger)
      bus.trigEcho <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bus.resultData <= spa_pkg::DATA_RESET;
    else if (waitDone)
      bus.resultData <= bus.procResult;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bus.errFlag <= 1'b0;
    else if (errSet)
      bus.errFlag <= 1'b1;
    else if (errClr)
      bus.errFlag <= 1'b0;
  end
endmodule

// ---- rtl/spa_status_pdo_assembler.sv ----
// Purpose: Builds the eight-byte status message sent to the fieldbus master
// Assumes: Status and receive inputs on core_clk; driver end and limit are pins
// Notes:   Message is rebuilt every cycle; bytes 4..7 carry the result word
`timescale 1ns/1ns

// Functional notes
// - Byte 0: remote outputs, warning, alarm
// - Byte 1: fixed 0 and 1, motion flags
// - Start echo mirrors master start level
// - No end area: end after pulses
// - End area: end after pulses and in area
// - Driver select: end follows driver end
// - Moving while pulsing or sensorless home seek
// - At-home flag mirrors home position
// - Limiting flag follows drive limit state
// - Ready when not running, moving, alarmed
// - Start commands accepted only while ready
// - Echo last received command code
// - Byte 3: error flag, trigger echo, command code bits 13..8
// - Error flag on unexecutable sequence program
// - Result field carries read or monitor value
module spa_status_pdo_assembler (
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic [spa_pkg::REMOTE_OUT_CNT-1:0] remoteOuts,
  input  wire logic                               warningIn,
  input  wire logic                               alarmIn,
  input  wire logic                               seqRunning,
  input  wire logic                               pulseBusy,
  input  wire logic                               homeSeekBusy,
  input  wire logic                               atHome,
  input  wire logic                               inEndArea,
  input  wire logic [spa_pkg::END_SEL_W-1:0]      endAreaSelect,
  input  wire logic                               driverFinishSelect,
  input  wire logic                               driverEndPin,
  input  wire logic                               driverLimitPin,
  input  wire logic                               rxStart,
  input  wire logic                               rxTrigger,
  input  wire logic [spa_pkg::CMD_W-1:0]          rxCommand,
  input  wire logic [spa_pkg::DATA_W-1:0]         rxData,
  input  wire logic                               procDone,
  input  wire logic                               procFault,
  input  wire logic [spa_pkg::DATA_W-1:0]         procResult,
  input  wire logic                               seqExecFail,
  output logic      [spa_pkg::PDO_W-1:0]          txPdo,
  output logic                                    readyFlag,
  output logic                                    seqStartReq,
  output logic                                    cmdIssueValid,
  output logic      [spa_pkg::CMD_W-1:0]          cmdIssueCode,
  output logic      [spa_pkg::DATA_W-1:0]         cmdIssueData
);
  logic [spa_pkg::SYNC_PINS-1:0] pinSync1_reg;
  logic [spa_pkg::SYNC_PINS-1:0] pinSync2_reg;
  logic [spa_pkg::SYNC_PINS-1:0] pinRaw;
  logic                          startPrev_reg;
  logic                          startRise;
  logic                          movingNow;
  logic                          readyNow;
  logic                          motionEnd;
  logic [7:0]                    stat0;
  logic [7:0]                    stat1;
  logic [7:0]                    flags3;
  logic [spa_pkg::PDO_W-1:0]     pdo_next;
  logic [spa_pkg::PDO_W-1:0]     pdo_reg;
  logic                          ready_reg;
  logic                          seqStart_reg;

  spa_cmd_if cmdBus ();

  assign pinRaw[spa_pkg::PIN_END]   = driverEndPin;
  assign pinRaw[spa_pkg::PIN_LIMIT] = driverLimitPin;

  // Driver pins are asynchronous to core_clk
  generate
    for (genvar i = 0; i < spa_pkg::SYNC_PINS; i++)
    begin : g_pinSync
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pinSync1_reg[i] <= 1'b0;
          pinSync2_reg[i] <= 1'b0;
        end
        else
        begin
          pinSync1_reg[i] <= pinRaw[i];
          pinSync2_reg[i] <= pinSync1_reg[i];
        end
      end
    end
  endgenerate

  always_comb
  begin
    movingNow = pulseBusy | homeSeekBusy;
    readyNow  = ~seqRunning & ~movingNow & ~alarmIn;
    startRise = rxStart & ~startPrev_reg;
  end

  spa_motion_end u_motionEnd (
    .endAreaSelect      (endAreaSelect),
    .driverFinishSelect (driverFinishSelect),
    .pulseBusy          (pulseBusy),
    .inEndArea          (inEndArea),
    .driverEnd          (pinSync2_reg[spa_pkg::PIN_END]),
    .motionEnd          (motionEnd)
  );

  assign cmdBus.trigger    = rxTrigger;
  assign cmdBus.cmdIn      = rxCommand;
  assign cmdBus.dataIn     = rxData;
  assign cmdBus.ready      = readyNow;
  assign cmdBus.startClr   = startRise & readyNow;
  // A refused start counts as a program that cannot run
  assign cmdBus.startFault = (startRise & ~readyNow) | seqExecFail;
  assign cmdBus.procDone   = procDone;
  assign cmdBus.procFault  = procFault;
  assign cmdBus.procResult = procResult;

  spa_cmd_handshake u_handshake (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (cmdBus)
  );

  always_comb
  begin
    stat0 = '0;
    stat0[spa_pkg::REMOTE_OUT_CNT-1:0]      = remoteOuts;
    stat0[spa_pkg::WARNING_BIT]             = warningIn;
    stat0[spa_pkg::ALARM_BIT]               = alarmIn;
    stat1 = '0;
    stat1[spa_pkg::FIXED_ZERO_BIT]          = 1'b0;
    stat1[spa_pkg::FIXED_ONE_BIT]           = 1'b1;
    stat1[spa_pkg::READY_BIT]               = readyNow;
    stat1[spa_pkg::LIMIT_BIT]               = pinSync2_reg[spa_pkg::PIN_LIMIT];
    stat1[spa_pkg::AT_HOME_BIT]             = atHome;
    stat1[spa_pkg::MOVING_BIT]              = movingNow;
    stat1[spa_pkg::MOTION_END_BIT]          = motionEnd;
    stat1[spa_pkg::START_ECHO_BIT]          = rxStart;
    flags3 = '0;
    flags3[spa_pkg::CMD_W-9:0]              = cmdBus.cmdEcho[spa_pkg::CMD_W-1:8];
    flags3[spa_pkg::TRIGGER_REQUEST_ECHO_BIT]          = cmdBus.trigEcho;
    flags3[spa_pkg::ERROR_BIT]              = cmdBus.errFlag;
    pdo_next = {cmdBus.resultData, flags3, cmdBus.cmdEcho[7:0], stat1, stat0};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pdo_reg <= spa_pkg::PDO_RESET;
    else
      pdo_reg <= pdo_next;
  end

  // Sequence start only on a rising edge seen while ready
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      startPrev_reg <= 1'b0;
      seqStart_reg  <= 1'b0;
      ready_reg     <= 1'b0;
    end
    else
    begin
      startPrev_reg <= rxStart;
      seqStart_reg  <= startRise & readyNow;
      ready_reg     <= readyNow;
    end
  end

  assign txPdo         = pdo_reg;
  assign readyFlag     = ready_reg;
  assign seqStartReq   = seqStart_reg;
  assign cmdIssueValid = cmdBus.issueValid;
  assign cmdIssueCode  = cmdBus.issueCode;
  assign cmdIssueData  = cmdBus.issueData;

  // Guarded on sampled reset: the edge that releases reset still loads the reset image
  property p_byte0;
    @(posedge core_clk) disable iff (rst)
      !rst |=> txPdo[7:0] == $past({alarmIn, warningIn, remoteOuts});
  endproperty
  a_byte0: assert property (p_byte0) else $error("byte 0 mismatch");

  property p_fixed_bits;
    @(posedge core_clk) disable iff (rst)
      txPdo[15:14] == 2'b01;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong");

  property p_start_echo;
    @(posedge core_clk) disable iff (rst)
      !rst |=> txPdo[8] == $past(rxStart);
  endproperty
  a_start_echo: assert property (p_start_echo) else $error("start echo wrong");

  property p_end_pulse;
    @(posedge core_clk) disable iff (rst)
      (!rst && !driverFinishSelect && endAreaSelect == '0) |=> txPdo[9] == !$past(pulseBusy);
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("end flag wrong");

  property p_end_area;
    @(posedge core_clk) disable iff (rst)
      (!driverFinishSelect && endAreaSelect != '0 && !inEndArea) |=> !txPdo[9];
  endproperty
  a_end_area: assert property (p_end_area) else $error("end outside area");

  property p_end_driver;
    @(posedge core_clk) disable iff (rst)
      (driverFinishSelect && $past(driverEndPin, 2) == $past(driverEndPin, 3))
        |=> txPdo[9] == $past(driverEndPin, 3);
  endproperty
  a_end_driver: assert property (p_end_driver) else $error("driver end lost");

  property p_moving;
    @(posedge core_clk) disable iff (rst)
      (pulseBusy || homeSeekBusy) |=> txPdo[10] && !txPdo[13];
  endproperty
  a_moving: assert property (p_moving) else $error("moving flag wrong");

  property p_home;
    @(posedge core_clk) disable iff (rst)
      $rose(atHome) |=> txPdo[11];
  endproperty
  a_home: assert property (p_home) else $error("home flag wrong");

  property p_limit;
    @(posedge core_clk) disable iff (rst)
      $rose(driverLimitPin) ##1 driverLimitPin ##1 driverLimitPin ##1 driverLimitPin
        |-> txPdo[12];
  endproperty
  a_limit: assert property (p_limit) else $error("limit flag late");

  property p_ready;
    @(posedge core_clk) disable iff (rst)
      !rst |=> txPdo[13] == !($past(seqRunning) || $past(pulseBusy) ||
                              $past(homeSeekBusy) || $past(alarmIn));
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");

  property p_start_gate;
    @(posedge core_clk) disable iff (rst)
      (cmdIssueValid && spa_pkg::spa_is_motion_start(cmdIssueCode)) || seqStartReq
        |-> $past(readyNow);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start while busy");

  property p_cmd_echo;
    @(posedge core_clk) disable iff (rst)
      cmdIssueValid |=> {txPdo[29:24], txPdo[23:16]} == $past(cmdIssueCode);
  endproperty
  a_cmd_echo: assert property (p_cmd_echo) else $error("command echo wrong");

  property p_trigger_request_set;
    @(posedge core_clk) disable iff (rst)
      (cmdBus.pending && procDone) |=> ##1 txPdo[30];
  endproperty
  a_trigger_request_set: assert property (p_trigger_request_set) else $error("trigger echo not set");

  property p_error;
    @(posedge core_clk) disable iff (rst)
      (cmdBus.pending && procDone && procFault) |=> ##1 txPdo[31];
  endproperty
  a_error: assert property (p_error) else $error("error flag not set");

  property p_result;
    @(posedge core_clk) disable iff (rst)
      (cmdBus.pending && procDone) |=> ##1 txPdo[63:32] == $past(procResult, 2);
  endproperty
  a_result: assert property (p_result) else $error("result word wrong");

  property p_trigger_request_clear;
    @(posedge core_clk) disable iff (rst)
      (!rxTrigger && !procDone) ##1 (!rxTrigger && !procDone) |=> !txPdo[30];
  endproperty
  a_trigger_request_clear: assert property (p_trigger_request_clear) else $error("trigger echo stuck");

  property p_cov_start;
    @(posedge core_clk) disable iff (rst) seqStartReq;
  endproperty
  c_cov_start: cover property (p_cov_start);

  property p_cov_roundtrip;
    @(posedge core_clk) disable iff (rst) cmdIssueValid ##[1:20] txPdo[30];
  endproperty
  c_cov_roundtrip: cover property (p_cov_roundtrip);

  property p_cov_refused;
    @(posedge core_clk) disable iff (rst) $rose(rxTrigger) && !readyNow ##2 txPdo[31];
  endproperty
  c_cov_refused: cover property (p_cov_refused);

  property p_cov_driver_end;
    @(posedge core_clk) disable iff (rst) driverFinishSelect && $rose(txPdo[9]);
  endproperty
  c_cov_driver_end: cover property (p_cov_driver_end);
endmodule

// ---- test/spa_master_model.sv ----
// Purpose: Fieldbus master stand-in driving command, trigger and start
// Assumes: Bench holds cmdReq high for as long as the trigger should stand
// Notes:   Idle command field toggles so stale sampling shows up
`timescale 1ns/1ns
module spa_master_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cmdReq,
  input  wire logic [13:0] reqCode,
  input  wire logic [31:0] reqData,
  input  wire logic        startLvl,
  output logic             rxStart,
  output logic             rxTrigger,
  output logic      [13:0] rxCommand,
  output logic      [31:0] rxData
);
  logic loaded;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rxTrigger <= 1'b0;
      loaded    <= 1'b0;
      rxCommand <= 14'h0000;
      rxData    <= 32'h0000_0000;
    end
    else if (cmdReq && !loaded)
    begin
      // Code and data settle a cycle before the trigger rises
      rxCommand <= reqCode;
      rxData    <= reqData;
      loaded    <= 1'b1;
    end
    else if (cmdReq)
      rxTrigger <= 1'b1;
    else
    begin
      rxTrigger <= 1'b0;
      loaded    <= 1'b0;
      rxCommand <= ~rxCommand;
      rxData    <= ~rxData;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rxStart <= 1'b0;
    else
      rxStart <= startLvl;
  end
endmodule

// ---- test/spa_status_pdo_assembler_tb.sv ----
// Purpose: Self-checking bench for the status message assembler
// Assumes: Master stand-in drives trigger, command and start
// Notes:   Pins need three edges, so status checks wait three
`timescale 1ns/1ns
module spa_status_pdo_assembler_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] stVec = 16'h0000;
  logic [7:0]  endAreaSelect = 8'h00;
  logic        cmdReq = 1'b0;
  logic        startLvl = 1'b0;
  logic        procDone = 1'b0;
  logic        procFault = 1'b0;
  logic        seqExecFail = 1'b0;
  logic [13:0] reqCode = 14'h0000;
  logic [31:0] reqData = 32'h0000_0000;
  logic [31:0] procResult = 32'h0000_0000;
  logic        rxStart, rxTrigger, readyFlag, seqStartReq, cmdIssueValid;
  logic [13:0] rxCommand, cmdIssueCode;
  logic [31:0] rxData, cmdIssueData;
  logic [63:0] txPdo;
  int          errors = 0;
  int          samplesChecked = 0;
  int          cyc = 0;

  spa_master_model master (
    .core_clk(core_clk), .rst(rst), .cmdReq(cmdReq), .reqCode(reqCode),
    .reqData(reqData), .startLvl(startLvl), .rxStart(rxStart),
    .rxTrigger(rxTrigger), .rxCommand(rxCommand), .rxData(rxData)
  );

  spa_status_pdo_assembler uut (
    .core_clk(core_clk), .rst(rst), .remoteOuts(stVec[15:10]),
    .warningIn(stVec[9]), .alarmIn(stVec[8]), .seqRunning(stVec[7]),
    .pulseBusy(stVec[6]), .homeSeekBusy(stVec[5]), .atHome(stVec[4]),
    .inEndArea(stVec[3]), .endAreaSelect(endAreaSelect),
    .driverFinishSelect(stVec[2]), .driverEndPin(stVec[1]),
    .driverLimitPin(stVec[0]), .rxStart(rxStart), .rxTrigger(rxTrigger),
    .rxCommand(rxCommand), .rxData(rxData), .procDone(procDone),
    .procFault(procFault), .procResult(procResult), .seqExecFail(seqExecFail),
    .txPdo(txPdo), .readyFlag(readyFlag), .seqStartReq(seqStartReq),
    .cmdIssueValid(cmdIssueValid), .cmdIssueCode(cmdIssueCode),
    .cmdIssueData(cmdIssueData)
  );

  always #5 core_clk = ~core_clk;

  task automatic end_sim();
    if (errors == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Runaway guard, far above the fewer than a thousand cycles the run needs
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] expB1();
    logic mv;
    logic en;
    mv = stVec[6] | stVec[5];
    en = stVec[2] ? stVec[1] : (!stVec[6] && (endAreaSelect == 8'h00 || stVec[3]));
    return {2'b01, !(stVec[7] | mv | stVec[8]), stVec[0], stVec[4], mv, en, rxStart};
  endfunction

  task automatic t_status();
    for (logic [7:0] i = 0; i < 128; i++)
    begin
      @(posedge core_clk);
      stVec         <= {i[5:0], i[3:0], i[5:0]};
      endAreaSelect <= i[6] ? i : 8'h00;
      wt(3);
      chk("status", txPdo[15:0], {expB1(), stVec[8], stVec[9], stVec[15:10]});
      chk("ready", readyFlag, expB1() >> 5 & 8'h01);
    end
  endtask

  task automatic t_start(input logic alarm);
    logic seen;
    seen = 1'b0;
    @(posedge core_clk);
    stVec    <= {7'h00, alarm, 8'h00};
    startLvl <= 1'b1;
    for (int n = 0; n < 6 && !seen; n++)
    begin
      wt(1);
      seen = (seqStartReq === 1'b1);
    end
    chk("start req", seen, !alarm);
    chk("start echo", txPdo[8], 1'b1);
    chk("start error", txPdo[31], alarm);
    wt(1);
    chk("start pulse", seqStartReq, 1'b0);
    @(posedge core_clk);
    startLvl <= 1'b0;
    wt(2);
    chk("start low", txPdo[8], 1'b0);
  endtask

  task automatic t_cmd(input logic [13:0] code, input logic fault, input logic okIss);
    logic        seen;
    logic [31:0] res;
    seen = 1'b0;
    res  = {code, 4'h5, code};
    @(posedge core_clk);
    reqCode <= code;
    reqData <= ~res;
    cmdReq  <= 1'b1;
    for (int n = 0; n < 8 && !seen && txPdo[30] !== 1'b1; n++)
    begin
      wt(1);
      seen = (cmdIssueValid === 1'b1);
    end
    chk("issued", seen, okIss);
    if (seen)
    begin
      chk("issue", {cmdIssueData, 18'h0, cmdIssueCode}, {~res, 18'h0, code});
      wt(1);
      chk("pending", txPdo[30], 1'b0);
      @(posedge core_clk);
      procDone   <= 1'b1;
      procFault  <= fault;
      procResult <= res;
      @(posedge core_clk);
      procDone <= 1'b0;
      wt(1);
      chk("result", txPdo[63:32], res);
    end
    chk("cmd echo", {txPdo[29:24], txPdo[23:16]}, code);
    chk("trigger_request echo", txPdo[30], 1'b1);
    chk("error", txPdo[31], seen ? fault : 1'b1);
    @(posedge core_clk);
    cmdReq <= 1'b0;
    wt(3);
    chk("echo clear", txPdo[30], 1'b0);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset pdo", txPdo, spa_pkg::PDO_RESET);
    @(posedge core_clk);
    rst <= 1'b0;
    t_status();
    t_start(1'b0);
    @(posedge core_clk);
    seqExecFail <= 1'b1;
    @(posedge core_clk);
    seqExecFail <= 1'b0;
    wt(2);
    chk("exec fail", txPdo[31], 1'b1);
    t_cmd(14'h0140, 1'b0, 1'b1);
    t_start(1'b1);
    // Each refusal follows an accepted read so the error bit starts clear
    for (int c = 'h1c04; c <= 'h1c19; c++)
    begin
      if (c == 'h1c05 || (c >= 'h1c10 && c != 'h1c18))
      begin
        t_cmd(14'h0140, 1'b0, 1'b1);
        t_cmd(14'(c), 1'b0, 1'b0);
      end
    end
    @(posedge core_clk);
    stVec <= 16'h0000;
    t_cmd(14'h1c12, 1'b1, 1'b1);
    t_cmd(14'h1c1d, 1'b0, 1'b1);
    end_sim();
  end
endmodule
